// File: design/mix_router_defs.vh
/*
 * constants for the mixer input router: register offsets, field positions,
 * reset values and source/mode encodings.
 * assumes inclusion by bare name from design files only.
 */
`ifndef MIX_ROUTER_DEFS_VH
`define MIX_ROUTER_DEFS_VH

// register offsets (index into 8-bit address space)
`define ADDR_ROUTE0      8'h00
`define ADDR_STATUS      8'h08
`define ADDR_ROUTE_LAST  8'h07

// route register fields: [1:0] source, [4:2] pair select, [6:5] mode
`define F_SRC_LO         0
`define F_SRC_HI         1
`define F_SEL_LO         2
`define F_SEL_HI         4
`define F_MODE_LO        5
`define F_MODE_HI        6
`define ROUTE_W          7
`define ROUTE_RST        7'h00

// source codes
`define SRC_SDI          2'h0
`define SRC_AES          2'h1
`define SRC_ANALOG       2'h2
`define SRC_DECODE       2'h3

// handling modes
`define MODE_AUDIO       2'h0
`define MODE_DATA        2'h1
`define MODE_AUTO        2'h2

`endif

// File: design/pair_fifo.v
/*
 * synchronous fifo with valid/ready on both sides, flip-flop storage.
 * assumes one clock, clock enable freezing all state, async active-low reset.
 */
`timescale 1ns/1ns
module pair_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
)
(
  input  wire             clk,
  input  wire             nrst,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers and occupancy
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_reg  <= {AW{1'b0}};
      rd_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else if (ce)
    begin
      if (push)
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // storage, no reset needed on data
  always @(posedge clk)
  begin
    if (ce && push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule // pair_fifo

// File: design/mix_router.v
/*
 * mixer input router: eight mixer input pairs (sixteen channels, four groups
 * of four) each pick an sdi, aes, analog or decoder source pair and a
 * handling mode, and the routed frames pass a fifo to the mixer side.
 * assumes all sources present one sample pair per frame strobe on clk, with
 * pair lanes flattened: 8 sdi pairs, 8 aes pairs, 8 analog, 8 decoder pairs.
 */
// Added by the designer: the placing of the registers and strobed register access.
// Notes on behaviour
// - one selector per mixer pair, four groups of four channels, sixteen total.
// - decoder source feeds the chosen decoder output pair to the mixer pair.
// - sdi source feeds the chosen disembedded channel pair to the mixer pair.
// - every mixer pair holds its own mode: audio, data or automatic.
// - audio mode sends the pair as two pcm channels through the mixer.
// - data mode bypasses mixing so payload words pass bit exact.
// - data mode also keeps non-audio pcm payloads in aes format unaltered.
// - automatic mode follows the audio/data flag carried with each sdi or aes sample; analog and decoder pairs pass as audio.
// - sdi selection covers sixteen embedded channels as eight pairs.
// - a mixer pair may also take an aes or analog input pair.
`timescale 1ns/1ns
`include "mix_router_defs.vh"
module mix_router
#(
  parameter SW     = 24,
  parameter NPAIR  = 8,
  parameter NSRC   = 8,
  parameter DEPTH  = 16
)
(
  input  wire                     clk,
  input  wire                     nrst,
  input  wire                     ce,
  input  wire [7:0]               addr,
  input  wire [31:0]              wdata,
  input  wire                     wr,
  input  wire                     rd,
  output reg  [31:0]              rdata,
  input  wire                     frame,
  input  wire [NSRC*2*SW-1:0]     sdi_in,
  input  wire [NSRC-1:0]          sdi_flag,
  input  wire [NSRC*2*SW-1:0]     aes_in,
  input  wire [NSRC-1:0]          aes_flag,
  input  wire [NSRC*2*SW-1:0]     analog_in,
  input  wire [NSRC*2*SW-1:0]     dec_in,
  output reg  [NPAIR*2*SW-1:0]    mix_data,
  output reg  [NPAIR-1:0]         mix_bypass,
  output reg                      mix_valid,
  input  wire                     mix_ready,
  output reg                      overflow
);
  localparam FW = NPAIR*2*SW + NPAIR;

  // -------------------------------------------------------------
  // register file
  // -------------------------------------------------------------
  reg  [`ROUTE_W-1:0] shadow_reg [0:NPAIR-1];
  reg  [`ROUTE_W-1:0] live_reg   [0:NPAIR-1];
  reg                 ovf_reg;
  wire [FW-1:0]       frame_next;
  wire                f_in_ready;
  wire [FW-1:0]       f_out_data;
  wire                f_out_valid;
  wire                f_out_ready;

  genvar p;
  generate
    for (p = 0; p < NPAIR; p = p + 1)
    begin : g_pair
      wire [1:0] src  = live_reg[p][`F_SRC_HI:`F_SRC_LO];
      wire [2:0] sel  = live_reg[p][`F_SEL_HI:`F_SEL_LO];
      wire [1:0] mode = live_reg[p][`F_MODE_HI:`F_MODE_LO];
      reg  [2*SW-1:0] pick;
      reg             flag;
      reg             byp;

      // software writes land in the shadow copy
      // one selector each
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          shadow_reg[p] <= `ROUTE_RST;
        else if (ce && wr && addr == `ADDR_ROUTE0 + p)
          shadow_reg[p] <= wdata[`ROUTE_W-1:0];
      end

      // shadow moves to live on the frame strobe only
      // boundary-aligned update
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          live_reg[p] <= `ROUTE_RST;
        else if (ce && frame)
          live_reg[p] <= shadow_reg[p];
      end

      // source pair pick; three select bits give eight pairs
      always @*
      begin
        pick = {2*SW{1'b0}};
        flag = 1'b0;
        case (src)
          `SRC_SDI:
          begin
            pick = sdi_in[sel*2*SW +: 2*SW];
            flag = sdi_flag[sel];
          end
          `SRC_AES:
          begin
            pick = aes_in[sel*2*SW +: 2*SW];
            flag = aes_flag[sel];
          end
          `SRC_ANALOG:
            pick = analog_in[sel*2*SW +: 2*SW];
          `SRC_DECODE:
            pick = dec_in[sel*2*SW +: 2*SW];
          default:
            pick = {2*SW{1'b0}};
        endcase
      end

      // mode decides whether the mixer may touch the words
      // per-pair mode
      always @*
      begin
        byp = 1'b0;
        case (mode)
          `MODE_AUDIO: byp = 1'b0;
          `MODE_DATA:  byp = 1'b1;
          `MODE_AUTO:  byp = flag;
          default:     byp = 1'b0;
        endcase
      end

      // each pair owns its own slice of the frame word, so one driver per bit
      assign frame_next[p*2*SW +: 2*SW] = pick;
      assign frame_next[NPAIR*2*SW + p] = byp;
    end
  endgenerate

  // -------------------------------------------------------------
  // frame buffering towards the mixer
  // -------------------------------------------------------------
  // sdi and aes paths run together
  pair_fifo #(.WIDTH(FW), .DEPTH(DEPTH), .AW($clog2(DEPTH))) u_fifo
  (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_data   (frame_next),
    .in_valid  (frame),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // output stage: refill when empty or consumed
  assign f_out_ready = ~mix_valid | mix_ready;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mix_valid  <= 1'b0;
      mix_data   <= {NPAIR*2*SW{1'b0}};
      mix_bypass <= {NPAIR{1'b0}};
    end
    else if (ce && f_out_ready)
    begin
      mix_valid <= f_out_valid;
      if (f_out_valid)
      begin
        mix_data   <= f_out_data[NPAIR*2*SW-1:0];
        mix_bypass <= f_out_data[FW-1:NPAIR*2*SW];
      end
    end
  end

  // sticky overflow: a frame lost to a full fifo; set beats clear
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ovf_reg <= 1'b0;
    else if (ce)
    begin
      if (frame && !f_in_ready)
        ovf_reg <= 1'b1;
      else if (wr && addr == `ADDR_STATUS && wdata[0])
        ovf_reg <= 1'b0;
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      overflow <= 1'b0;
    else if (ce)
      overflow <= ovf_reg;
  end

  // read data one cycle after strobe, zero otherwise
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 32'h0000_0000;
    else if (ce)
    begin
      rdata <= 32'h0000_0000;
      if (rd && addr <= `ADDR_ROUTE_LAST)
        rdata <= {{(32-`ROUTE_W){1'b0}}, shadow_reg[addr[2:0]]};
      else if (rd && addr == `ADDR_STATUS)
        rdata <= {30'h0, f_out_valid, ovf_reg};
    end
  end
endmodule // mix_router

// File: test/mix_router_sva.sv
/* port checker for mix_router.
   assumes ce only drops while no frame or read is in flight, and the bus never strobes wr and rd together. */
`timescale 1ns/1ns
module mix_router_sva
#(
  parameter SW    = 24,
  parameter NPAIR = 8
)
(
  input wire clk, nrst, wr, rd, frame, mix_ready, mix_valid, overflow,
  input wire [7:0]            addr,
  input wire [31:0]           rdata,
  input wire [NPAIR*2*SW-1:0] mix_data,
  input wire [NPAIR-1:0]      mix_bypass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // read data only in the cycle after a read strobe
  property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
  property p_rd_unmap; $past(rd) && $past(addr) > 8'h08 |-> rdata == 32'h0; endproperty
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
  property p_rd_route; $past(rd) && $past(addr) < 8'h08 |-> rdata[31:7] == 25'h0; endproperty
  a_rd_route: assert property (p_rd_route) else $error("route read width");
  // a stalled frame must not tear while the mixer waits
  property p_hold; mix_valid && !mix_ready |=> mix_valid && $stable(mix_data); endproperty
  a_hold: assert property (p_hold) else $error("frame changed while stalled");
  property p_byp_hold; mix_valid && !mix_ready |=> $stable(mix_bypass); endproperty
  a_byp_hold: assert property (p_byp_hold) else $error("bypass changed while stalled");
  property p_latency; frame && !$past(frame) && !mix_valid && mix_ready |-> ##2 mix_valid; endproperty
  a_latency: assert property (p_latency) else $error("frame latency");
  property p_ovf_rise; $rose(overflow) |-> $past(mix_valid, 2); endproperty
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow with room");
  property p_ovf_fall; $fell(overflow) |-> $past(wr, 2) && $past(addr, 2) == 8'h08; endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow cleared alone");
endmodule // mix_router_sva

bind mix_router mix_router_sva #(.SW(SW), .NPAIR(NPAIR)) i_mix_router_sva (.clk(clk), .nrst(nrst), .wr(wr),
  .rd(rd), .frame(frame), .mix_ready(mix_ready), .mix_valid(mix_valid), .overflow(overflow), .addr(addr),
  .rdata(rdata), .mix_data(mix_data), .mix_bypass(mix_bypass));

// File: test/sdi_source.sv
/* disembedded sdi source: eight pairs with data flags.
   assumes step is the frame strobe of the router's clock. */
`timescale 1ns/1ns
module sdi_source
(
  input  wire         clk,
  input  wire         nrst,
  input  wire         step,
  output reg  [383:0] sdi_in,
  output reg  [7:0]   sdi_flag
);
  // lanes churn off-frame so stale samples never pass for fresh ones
  // eight pairs
  always @(posedge clk or negedge nrst)
    if (!nrst)
      {sdi_in, sdi_flag} <= 392'h0;
    else if (!step)
      {sdi_in, sdi_flag} <= {sdi_in[370:0], sdi_in[383:371] ^ 13'h1a5b, sdi_in[300:293]};
endmodule // sdi_source

// File: test/testbench.sv
/* random and corner tests of mix_router.
   assumes sdi_source drives the sdi lanes; ce held high except during one write test. */
`timescale 1ns/1ns
module testbench;
  reg          clk, nrst, ce, wr, rd, frame, mix_ready;
  reg  [7:0]   addr, aes_flag, s_flag, eb;
  reg  [31:0]  wdata, lf, d;
  reg  [383:0] aes_in, analog_in, dec_in, s_sdi, ed;
  reg  [6:0]   route [0:7];
  reg  [6:0]   prev [0:7];
  wire [383:0] sdi_in, mix_data;
  wire [7:0]   sdi_flag, mix_bypass;
  wire [31:0]  rdata;
  wire         mix_valid, overflow;
  integer      miscompares, cmp_count, p, r, t;
  mix_router i_mix_router (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .frame(frame), .sdi_in(sdi_in), .sdi_flag(sdi_flag), .aes_in(aes_in), .aes_flag(aes_flag),
    .analog_in(analog_in), .dec_in(dec_in), .mix_data(mix_data), .mix_bypass(mix_bypass), .mix_valid(mix_valid),
    .mix_ready(mix_ready), .overflow(overflow));
  sdi_source i_sdi_source (.clk(clk), .nrst(nrst), .step(frame), .sdi_in(sdi_in), .sdi_flag(sdi_flag));
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task final_report;
  begin
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task bump(input bad);
  begin
    cmp_count = cmp_count + 1;
    if (bad)
    begin
      miscompares = miscompares + 1;
      $display("mismatch %0t value", $time);
    end
  end
  endtask
  task chk_data(input [383:0] g, e); bump(g !== e); endtask
  task chk_word(input [31:0] g, e); bump(g !== e); endtask
  // bus master: strobes set just after an edge, read data one cycle later
  task bus_wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  end
  endtask
  task bus_rd(input [7:0] a);
  begin
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  end
  endtask
  // new random lanes with one frame strobe; sdi snapshot taken after the edge
  task send_frame;
    integer i;
  begin
    @(posedge clk);
    for (i = 0; i < 12; i = i + 1)
    begin
      lf = nx(lf);
      aes_in[i*32+:32] <= lf; analog_in[i*32+:32] <= ~lf; dec_in[i*32+:32] <= {lf[15:0], lf[31:16]};
    end
    aes_flag <= lf[9:2]; frame <= 1'b1;
    @(posedge clk); frame <= 1'b0;
    #1 s_sdi = sdi_in; s_flag = sdi_flag;
  end
  endtask
  // bounded wait for mix_valid to reach v
  task wait_for(input v);
  begin
    t = 0;
    do begin @(posedge clk); #1 t = t + 1; end while (mix_valid !== v && t < 40);
    if (mix_valid !== v)
    begin
      bump(1'b1);
      final_report;
    end
  end
  endtask
  // expected frame from either the settings just written or the ones live before
  task calc(input o);
    reg [2:0] k;
    reg [1:0] s;
    reg [6:0] rt;
  begin
    for (p = 0; p < 8; p = p + 1)
    begin
      rt = o ? prev[p] : route[p];
      s = rt[1:0]; k = rt[4:2];
      case (s)
        2'h0: ed[p*48+:48] = s_sdi[k*48+:48];
        2'h1: ed[p*48+:48] = aes_in[k*48+:48];
        2'h2: ed[p*48+:48] = analog_in[k*48+:48];
        default: ed[p*48+:48] = dec_in[k*48+:48];
      endcase
      eb[p] = rt[6:5] == 2'h1 || rt[6:5] == 2'h2 && (s == 2'h0 ? s_flag[k] : s == 2'h1 && aes_flag[k]);
    end
  end
  endtask
  initial
  begin
    {nrst, wr, rd, frame, addr, wdata, aes_flag, aes_in, analog_in, dec_in} = 0;
    mix_ready = 1; ce = 1; lf = 32'h62; miscompares = 0; cmp_count = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // pass 0 is the corner set: sdi auto lanes, pair 7 decoder lane 7 data
    for (r = 0; r < 6; r = r + 1)
    begin
      for (p = 0; p < 8; p = p + 1)
      begin
        lf = nx(lf);
        prev[p] = r ? route[p] : 7'h00;
        route[p] = r ? lf[6:0] : p == 7 ? 7'h3f : {2'h2, p[2:0], 2'h0};
        bus_wr(p[7:0], {25'h0, route[p]});
      end
      for (p = 0; p < 8; p = p + 1)
      begin
        bus_rd(p[7:0]);
        chk_word(d, {25'h0, route[p]});
      end
      // first frame still rides on the settings live before the writes
      send_frame; wait_for(1'b1);
      calc(1'b1);
      chk_data(mix_data, ed);
      chk_word({24'h0, mix_bypass}, {24'h0, eb});
      send_frame; wait_for(1'b1);
      calc(1'b0);
      chk_data(mix_data, ed);
      chk_word({24'h0, mix_bypass}, {24'h0, eb});
      $display("route test %0d done", r);
    end
    bus_rd(8'h20);
    chk_word(d, 32'h0);
    // a write while the clock enable is low must leave the route untouched
    @(posedge clk); ce <= 1'b0;
    bus_wr(8'h00, {25'h0, ~route[0]});
    ce <= 1'b1;
    bus_rd(8'h00);
    chk_word(d, {25'h0, route[0]});
    @(posedge clk); mix_ready <= 1'b0;
    repeat (18) send_frame;
    bus_rd(8'h08);
    chk_word({d[30:0], overflow}, 32'h7);
    bus_wr(8'h08, 32'h1);
    bus_rd(8'h08);
    chk_word(d, 32'h2);
    @(posedge clk); mix_ready <= 1'b1;
    wait_for(1'b0);
    bus_rd(8'h08);
    chk_word(d, 32'h0);
    $display("overflow test done");
    // a second reset mid-run returns route register 0 to its reset value
    bus_wr(8'h00, 32'h7f);
    @(posedge clk); nrst <= 1'b0;
    @(posedge clk); nrst <= 1'b1;
    bus_rd(8'h00);
    chk_word(d, 32'h0);
    $display("reset test done");
    final_report;
  end
endmodule // testbench
